// ===== src/plc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "plc_params.svh"
module plc_core #(
	parameter int DATA_W = `PLC_DATA_W,
	parameter int DEPTH  = `PLC_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// Serial request line from the link
	input  wire logic              lreq_in,
	input  wire logic              long_form_in,
	// Static controls
	input  wire logic              arb_accel_enable_bit_in,
	input  wire logic              multispeed_concat_enable_bit_in,
	input  wire logic              link_speed_we_in,
	input  wire plc_pkg::plc_speed_t link_speed_in,
	input  wire logic              bus_reset_in,
	// Received packet stream
	input  wire logic [DATA_W-1:0] rx_data_in,
	input  wire logic              rx_valid_in,
	output logic                   rx_ready_out,
	output logic      [DATA_W-1:0] link_data_out,
	output logic                   link_valid_out,
	input  wire logic              link_ready_in,
	// Transmit side
	output plc_pkg::plc_speed_t    tx_speed_out,
	output logic                   tx_prefix_out,
	output logic                   tx_end_out,
	output logic                   tx_null_out,
	output logic                   concat_ok_out,
	output logic                   accel_on_out,
	output logic                   req_done_out,
	output logic      [2:0]        req_type_out,
	// Self-ID speeds
	output plc_pkg::plc_speed_t    selfid_speed_out,
	output plc_pkg::plc_speed_t    peer_speed_out
);
	import plc_pkg::*;

	plc_state_e  state_reg;
	logic [7:0]  sh_reg;
	logic [3:0]  cnt_reg;
	logic [3:0]  len_reg;
	logic        lr_prev_reg;
	plc_speed_t  link_speed_reg;
	plc_speed_t  speed_dec;
	logic        over_dec;
	logic        accel_reg;
	logic        null_reg;
	logic [3:0]  need;
	logic [7:0]  bits_now;
	logic        fifo_valid;
	logic [DATA_W-1:0] fifo_data;
	logic        fifo_ready;
	localparam int OW = $clog2(DEPTH) + 1;
	logic [OW-1:0] occ_reg;
	logic [OW-1:0] occ_next;
	logic        rx_push;
	logic        fifo_pop;

	// Request length by form
	function automatic logic [3:0] req_len(input logic long_f);
		req_len = long_f ? `PLC_LONG_LEN : `PLC_SHORT_LEN;
	endfunction

	assign need     = req_len(long_form_in);
	assign bits_now = {sh_reg[6:0], lreq_in};

	plc_req_decode u_dec (
		.req_bits_in (sh_reg),
		.req_long_in (len_reg == `PLC_LONG_LEN),
		.speed_out   (speed_dec),
		.over_out    (over_dec)
	);

	// Request framing: start bit then type and speed bits, new start may follow directly
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg    <= PLC_IDLE;
			sh_reg       <= 8'h00;
			cnt_reg      <= 4'h0;
			len_reg      <= 4'h0;
			req_done_out <= 1'b0;
			req_type_out <= 3'h0;
		end else begin
			req_done_out <= 1'b0;
			case (state_reg)
				PLC_IDLE: begin
					if (lreq_in) begin
						state_reg <= PLC_REQ;
						cnt_reg   <= 4'h1;
						len_reg   <= need;
						sh_reg    <= 8'h00;
					end
				end
				PLC_REQ: begin
					sh_reg  <= bits_now;
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == len_reg - 4'h1) begin
						state_reg    <= PLC_IDLE;
						req_done_out <= 1'b1;
						// Type sits above the speed field and the stop bit
						req_type_out <= (len_reg == `PLC_LONG_LEN) ? bits_now[6:4]
						                                          : bits_now[5:3];
					end
				end
				default: state_reg <= PLC_IDLE;
			endcase
		end
	end

	// Transmit prefix speed on each finished bus request, then a null packet when the speed code is out of range
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tx_speed_out  <= `PLC_SPD_LOW;
			tx_prefix_out <= 1'b0;
			tx_end_out    <= 1'b0;
			tx_null_out   <= 1'b0;
			null_reg      <= 1'b0;
		end else begin
			tx_prefix_out <= 1'b0;
			tx_end_out    <= null_reg;
			tx_null_out   <= null_reg;
			null_reg      <= 1'b0;
			if (req_done_out && req_type_out == `PLC_REQ_BUS) begin
				tx_prefix_out <= 1'b1;
				tx_speed_out  <= speed_dec;
				null_reg      <= over_dec;
			end
		end
	end

	// Acceleration enable and its temporary override
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			accel_reg    <= 1'b0;
			accel_on_out <= 1'b0;
			lr_prev_reg  <= 1'b0;
		end else begin
			lr_prev_reg <= lreq_in;
			if (!arb_accel_enable_bit_in) begin
				accel_reg <= 1'b0;
			end else if (req_done_out && req_type_out == `PLC_REQ_ACCEL) begin
				accel_reg <= sh_reg[1]; // Speed-field lsb picks on or off
			end else if (!accel_reg && !lr_prev_reg) begin
				accel_reg <= 1'b1;
			end
			accel_on_out <= arb_accel_enable_bit_in && accel_reg;
		end
	end

	// Concatenation permission
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			concat_ok_out <= 1'b0;
		end else begin
			concat_ok_out <= multispeed_concat_enable_bit_in;
		end
	end

	// Link speed field: hardware reset only, bus reset ignored
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			link_speed_reg <= `PLC_LINK_SPD_RST;
		end else if (link_speed_we_in && link_speed_in != `PLC_SPD_BAD) begin
			link_speed_reg <= link_speed_in;
		end
	end

	// Self-ID reports field, peers always see top rate
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			selfid_speed_out <= `PLC_LINK_SPD_RST;
			peer_speed_out   <= `PLC_SPD_TOP;
		end else begin
			selfid_speed_out <= link_speed_reg;
			peer_speed_out   <= `PLC_SPD_TOP;
		end
	end

	// Fill level mirror, so a registered ready never promises a slot that is gone
	assign rx_push  = rx_valid_in && rx_ready_out;
	assign fifo_pop = fifo_valid && (!link_valid_out || link_ready_in);
	assign occ_next = occ_reg + OW'(rx_push) - OW'(fifo_pop);

	// Ready for next cycle only while a slot will still be free then
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			occ_reg      <= '0;
			rx_ready_out <= 1'b0;
		end else begin
			occ_reg      <= occ_next;
			rx_ready_out <= (occ_next < OW'(DEPTH));
		end
	end

	// All received data is queued for the link
	plc_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.wr_data_in   (rx_data_in),
		.wr_valid_in  (rx_push),
		.wr_ready_out (fifo_ready),
		.rd_data_out  (fifo_data),
		.rd_valid_out (fifo_valid),
		.rd_ready_in  (!link_valid_out || link_ready_in)
	);

	// Output stage registered
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			link_valid_out <= 1'b0;
			link_data_out  <= '0;
		end else begin
			if (!link_valid_out || link_ready_in) begin
				link_valid_out <= fifo_valid;
				link_data_out  <= fifo_data;
			end
		end
	end

	// Checks on reset values and the link speed field
	a_peer_top: assert property (@(posedge clk_in) disable iff (rst_in)
		$past(!rst_in) |-> peer_speed_out == `PLC_SPD_TOP)
		else $error("peer speed not top");
	a_speed_reset: assert property (@(posedge clk_in)
		rst_in |=> link_speed_reg == `PLC_LINK_SPD_RST)
		else $error("link speed reset wrong");
	a_bus_reset_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		bus_reset_in && !link_speed_we_in |=> $stable(link_speed_reg))
		else $error("bus reset changed speed");
	a_no_illegal: assert property (@(posedge clk_in) disable iff (rst_in)
		link_speed_reg != `PLC_SPD_BAD)
		else $error("illegal link speed");
	a_speed_write: assert property (@(posedge clk_in) disable iff (rst_in)
		link_speed_we_in && link_speed_in != `PLC_SPD_BAD
		|=> link_speed_reg == $past(link_speed_in))
		else $error("link speed write lost");
	a_selfid: assert property (@(posedge clk_in) disable iff (rst_in)
		$past(!rst_in) |-> selfid_speed_out == $past(link_speed_reg))
		else $error("self-id speed wrong");

	// Checks on the static enables
	a_accel_off: assert property (@(posedge clk_in) disable iff (rst_in)
		!arb_accel_enable_bit_in |=> !accel_on_out)
		else $error("accel on while disabled");
	a_concat_gate: assert property (@(posedge clk_in) disable iff (rst_in)
		!multispeed_concat_enable_bit_in |=> !concat_ok_out)
		else $error("concat while disabled");
	a_concat_on: assert property (@(posedge clk_in) disable iff (rst_in)
		multispeed_concat_enable_bit_in |=> concat_ok_out)
		else $error("concat off while enabled");

	// Checks on request framing, one state per shifted bit
	sequence s_short_body;
		(state_reg == PLC_REQ) [*6];
	endsequence
	sequence s_long_body;
		(state_reg == PLC_REQ) [*7];
	endsequence
	a_req_len: assert property (@(posedge clk_in) disable iff (rst_in)
		state_reg == PLC_IDLE && lreq_in && !long_form_in
		|=> s_short_body ##1 req_done_out)
		else $error("short request length wrong");
	a_long_len: assert property (@(posedge clk_in) disable iff (rst_in)
		state_reg == PLC_IDLE && lreq_in && long_form_in
		|=> s_long_body ##1 req_done_out)
		else $error("long request length wrong");
	a_prefix_follow: assert property (@(posedge clk_in) disable iff (rst_in)
		req_done_out && req_type_out == `PLC_REQ_BUS |=> tx_prefix_out)
		else $error("bus request without prefix");
	a_prefix_legal: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_prefix_out |-> tx_speed_out != `PLC_SPD_BAD)
		else $error("prefix speed illegal");
	a_tx_single: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_prefix_out |=> !tx_prefix_out)
		else $error("prefix repeated");

	// Checks on the null packet
	sequence s_null_start;
		tx_prefix_out && null_reg;
	endsequence
	a_null_pkt: assert property (@(posedge clk_in) disable iff (rst_in)
		s_null_start |=> tx_end_out && tx_null_out)
		else $error("null packet malformed");
	a_end_only_null: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_end_out |-> tx_null_out && $past(tx_prefix_out))
		else $error("end without prefix");

	// Checks on the received stream
	a_rx_fwd: assert property (@(posedge clk_in) disable iff (rst_in)
		link_valid_out && !link_ready_in |=> link_valid_out && $stable(link_data_out))
		else $error("link data dropped");
	a_rx_no_drop: assert property (@(posedge clk_in) disable iff (rst_in)
		rx_ready_out |-> fifo_ready)
		else $error("ready while queue full");
	a_occ_bound: assert property (@(posedge clk_in) disable iff (rst_in)
		occ_reg <= OW'(DEPTH))
		else $error("queue fill out of range");
endmodule
`default_nettype wire

// ===== inc/plc_params.svh
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH
`define PLC_SPD_LOW       2'h0
`define PLC_SPD_MID       2'h1
`define PLC_SPD_TOP       2'h2
`define PLC_SPD_BAD       2'h3
`define PLC_LINK_SPD_RST  2'h2
`define PLC_REQ_BUS       3'h1
`define PLC_REQ_ACCEL     3'h6
`define PLC_SC3_MID       3'h1
`define PLC_SC3_TOP       3'h2
`define PLC_SHORT_LEN     4'h7
`define PLC_LONG_LEN      4'h8
`define PLC_FIFO_DEPTH    16
`define PLC_DATA_W        8
`endif

// ===== inc/plc_pkg.sv
package plc_pkg;
	typedef logic [1:0] plc_speed_t;
	typedef enum logic [4:0] {
		PLC_IDLE = 5'h01,
		PLC_REQ  = 5'h02,
		PLC_PFX  = 5'h04,
		PLC_DATA = 5'h08,
		PLC_END  = 5'h10
	} plc_state_e;
endpackage

// ===== src/plc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module plc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// Fill side
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	// Drain side
	output logic      [WIDTH-1:0] rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wp_reg;
	logic [AW-1:0]    rp_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	// Handshake terms
	assign push         = wr_valid_in && wr_ready_out;
	assign pop          = rd_valid_out && rd_ready_in;
	assign wr_ready_out = (cnt_reg != (AW+1)'(DEPTH));
	assign rd_valid_out = (cnt_reg != '0);
	assign rd_data_out  = mem_reg[rp_reg];

	// Storage write
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_reg[wp_reg] <= wr_data_in;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ===== src/plc_req_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "plc_params.svh"
module plc_req_decode (
	// Captured request
	input  wire logic [7:0]         req_bits_in,
	input  wire logic               req_long_in,
	// Decoded speed
	output plc_pkg::plc_speed_t     speed_out,
	output logic                    over_out
);
	import plc_pkg::*;
	logic [2:0] code;

	// Both forms map to one speed scale
	always_comb begin
		// Bit 0 holds the stop bit, the speed field sits just above it
		code      = req_long_in ? req_bits_in[3:1] : {1'b0, req_bits_in[2:1]};
		over_out  = 1'b0;
		speed_out = `PLC_SPD_LOW;
		case (code)
			3'h0: speed_out = `PLC_SPD_LOW;
			`PLC_SC3_MID: speed_out = `PLC_SPD_MID;
			`PLC_SC3_TOP: speed_out = `PLC_SPD_TOP;
			default: over_out = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// ===== sim/plc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module plc_link_model (
	// Clock
	input  wire logic       clk_in,
	// Request line
	output logic            lreq_out,
	output logic            long_out,
	// Received stream
	input  wire logic [7:0] data_in,
	input  wire logic       valid_in,
	output logic            ready_out,
	input  wire logic       stall_in
);
	logic [7:0] got[$];
	// Start bit, type, speed, then a low stop bit so the line ends idle
	task automatic send(input logic lf, input logic [2:0] typ, input logic [2:0] spd);
		logic [7:0] bits;
		bits = lf ? {1'b1, typ, spd, 1'b0} : {1'b1, typ, spd[1:0], 2'h0};
		long_out = lf;
		for (int i = 0; i < (lf ? 8 : 7); i++) begin
			lreq_out = bits[7-i];
			@(posedge clk_in);
			#1;
		end
	endtask
	// Takes whatever is offered unless told to stall
	assign ready_out = !stall_in;
	always @(posedge clk_in) begin
		if (valid_in === 1'b1 && ready_out) got.push_back(data_in);
	end
	initial begin
		lreq_out = 1'b0;
		long_out = 1'b0;
	end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import plc_pkg::*;
	typedef struct packed {logic lf; logic [2:0] spd; logic [1:0] exp; logic nul;} plc_row_s;
	logic       clk_in = 1'b0, rst_in = 1'b1, accel_en = 1'b0, msc_en = 1'b0, spd_we = 1'b0;
	logic       bus_rst = 1'b0, rx_valid = 1'b0, stall = 1'b1, pfx_d = 1'b0, lreq, lf;
	logic       rx_ready, link_valid, link_ready, tx_prefix, tx_end, tx_null, concat_ok;
	logic       accel_on, req_done;
	logic [7:0] rx_data = 8'h00, link_data, sent[$];
	logic [2:0] req_type, types[$];
	plc_speed_t spd_val = 2'h0, tx_speed, selfid, peer, spds[$];
	int         n_errors = 0, checks_done = 0, cycles = 0, n_null = 0, nn;
	plc_row_s   rows[9] = '{'{1'b0, 3'h0, 2'h0, 1'b0}, '{1'b0, 3'h1, 2'h1, 1'b0},
		'{1'b0, 3'h2, 2'h2, 1'b0}, '{1'b0, 3'h3, 2'h0, 1'b1}, '{1'b1, 3'h0, 2'h0, 1'b0},
		'{1'b1, 3'h1, 2'h1, 1'b0}, '{1'b1, 3'h2, 2'h2, 1'b0}, '{1'b1, 3'h3, 2'h0, 1'b1},
		'{1'b1, 3'h7, 2'h0, 1'b1}};
	plc_core plc_core_i (.clk_in(clk_in), .rst_in(rst_in), .lreq_in(lreq), .long_form_in(lf),
		.arb_accel_enable_bit_in(accel_en), .multispeed_concat_enable_bit_in(msc_en),
		.link_speed_we_in(spd_we), .link_speed_in(spd_val), .bus_reset_in(bus_rst),
		.rx_data_in(rx_data), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
		.link_data_out(link_data), .link_valid_out(link_valid), .link_ready_in(link_ready),
		.tx_speed_out(tx_speed), .tx_prefix_out(tx_prefix), .tx_end_out(tx_end),
		.tx_null_out(tx_null), .concat_ok_out(concat_ok), .accel_on_out(accel_on),
		.req_done_out(req_done), .req_type_out(req_type), .selfid_speed_out(selfid),
		.peer_speed_out(peer));
	plc_link_model plc_link_model_i (.clk_in(clk_in), .lreq_out(lreq), .long_out(lf),
		.data_in(link_data), .valid_in(link_valid), .ready_out(link_ready), .stall_in(stall));
	// Clock
	always #4 clk_in = ~clk_in;
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic wr_spd(input logic [1:0] v);
		spd_val = v;
		spd_we = 1'b1;
		cyc(1);
		spd_we = 1'b0;
		cyc(2);
	endtask
	// Records decoded requests, prefix speeds and null packets; cuts a hang short
	always @(posedge clk_in) begin
		cycles++;
		if (cycles > 5000) begin
			n_errors++;
			$display("MISMATCH timeout expected %0d seen %0d", 5000, cycles);
			end_of_test();
		end else begin
			if (req_done === 1'b1) types.push_back(req_type);
			if (tx_prefix === 1'b1) spds.push_back(tx_speed);
			if (tx_end === 1'b1 && tx_null === 1'b1 && pfx_d) n_null++;
			pfx_d <= (tx_prefix === 1'b1);
		end
	end
	initial begin
		cyc(10);
		rst_in = 1'b0;
		chk("selfid reset", 8'h2, {6'h0, selfid});
		for (int c = 0; c < 4; c++) begin
			wr_spd(2'(c));
			chk("selfid", (c == 3) ? 8'h2 : 8'(c), {6'h0, selfid});
			chk("peer", 8'h2, {6'h0, peer});
		end
		wr_spd(2'h0);
		bus_rst = 1'b1;
		cyc(3);
		bus_rst = 1'b0;
		cyc(1);
		chk("selfid bus reset", 8'h0, {6'h0, selfid});
		rst_in = 1'b1;
		cyc(2);
		rst_in = 1'b0;
		chk("selfid hard reset", 8'h2, {6'h0, selfid});
		foreach (rows[i]) begin
			nn = n_null;
			plc_link_model_i.send(rows[i].lf, 3'h1, rows[i].spd);
			cyc(4);
			chk("type", 8'h1, {5'h0, types.pop_front()});
			chk("nulls", 8'(nn + int'(rows[i].nul)), 8'(n_null));
			if (!rows[i].nul) chk("speed", {6'h0, rows[i].exp}, {6'h0, spds.pop_front()});
			else spds.delete();
		end
		plc_link_model_i.send(1'b0, 3'h1, 3'h2);
		plc_link_model_i.send(1'b1, 3'h1, 3'h1);
		plc_link_model_i.send(1'b0, 3'h6, 3'h1);
		cyc(6);
		chk("b2b count", 8'h3, 8'(types.size()));
		chk("b2b last", 8'h6, {5'h0, types[2]});
		chk("b2b speed", 8'h1, {6'h0, spds[1]});
		chk("accel off", 8'h0, {7'h0, accel_on});
		accel_en = 1'b1;
		cyc(3);
		chk("accel on", 8'h1, {7'h0, accel_on});
		plc_link_model_i.send(1'b0, 3'h6, 3'h0);
		cyc(2);
		chk("accel req off", 8'h0, {7'h0, accel_on});
		cyc(1);
		chk("accel rearmed", 8'h1, {7'h0, accel_on});
		chk("concat off", 8'h0, {7'h0, concat_ok});
		msc_en = 1'b1;
		cyc(2);
		chk("concat on", 8'h1, {7'h0, concat_ok});
		for (int k = 0; k < 40; k++) begin
			rx_valid = 1'b1;
			rx_data = 8'(sent.size() * 37 + 5);
			@(posedge clk_in);
			if (rx_ready === 1'b1) sent.push_back(rx_data);
			#1;
		end
		rx_valid = 1'b0;
		chk("fifo refused", 8'h1, {7'h0, sent.size() >= 16 && sent.size() < 40});
		for (int k = 0; k < 120; k++) begin
			stall = k[1];
			cyc(1);
		end
		chk("rx count", 8'(sent.size()), 8'(plc_link_model_i.got.size()));
		foreach (sent[i]) chk("rx data", sent[i], plc_link_model_i.got[i]);
		end_of_test();
	end
endmodule
`default_nettype wire
